// ===== hdl/bcb_top.sv
// Function
// - Hall latches close on change, two ticks
// - Six lockout flags, clear two ticks after off
// - Flag blocks opposing driver; two-tick dead time
// - Valid code: one low, one high on
// - Forward direction decode table
// - Reverse direction decode table
// - Invalid code turns every driver off
// - Quadrant select high gives four-quadrant chopping
// - Hall change reloads latches, fires tach pulse
// - Tach pulse keeps position latches closed

`timescale 1ns/1ps
`include "bcb_params.svh"

module bcb_top
    import bcb_pkg::*;
#(
    parameter int OSC_DIV = `BCB_OSC_DIV,
    parameter int TACH_CYC = `BCB_TACH_CYC,
    parameter logic [7:0] BLANK_TICKS = `BCB_BLANK_TICKS,
    parameter logic [7:0] DEAD_TICKS = `BCB_DEAD_TICKS
) (
    input wire logic mclk, // System clock, 25 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic position_sense_first, // Hall sensor 1 pin
    input wire logic position_sense_second, // Hall sensor 2 pin
    input wire logic position_sense_third, // Hall sensor 3 pin
    input wire logic direction, // Rotation direction pin
    input wire logic quad_select, // Four-quadrant select pin
    input wire logic pwm_on, // PWM latch state, high = conduct
    output logic low_side_drive_a, // Low-side A, high = on
    output logic low_side_drive_b, // Low-side B, high = on
    output logic low_side_drive_c, // Low-side C, high = on
    output logic high_side_drive_a_n, // High-side A, low = pulling on
    output logic high_side_drive_b_n, // High-side B, low = pulling on
    output logic high_side_drive_c_n, // High-side C, low = pulling on
    output logic tach_out, // Tachometer pulse
    output logic quad_mode // Four-quadrant mode in force
);

    localparam logic [15:0] OSC_LAST = 16'(OSC_DIV - 1);
    localparam logic [15:0] TACH_LOAD = 16'(TACH_CYC);

    localparam bcb_top_t TOP_RST = '{
        sync1: '0,
        sync2: '0,
        osc_cnt: 16'h0000,
        osc_tick: 1'b0,
        pos: 3'h0,
        blank_cnt: 8'h00,
        tach_cnt: 16'h0000,
        tach: 1'b0,
        drv_lo: `BCB_LOW_OFF,
        drv_hi_n: `BCB_HIGH_OFF_N,
        quad: 1'b0
    };

    bcb_top_t s;
    bcb_top_t next_s;

    logic [2:0] hall;
    logic dir_s;
    logic quad_s;
    logic chop_s;
    logic [5:0] decoded;
    logic [2:0] req_hi;
    logic [2:0] req_lo;
    logic [2:0] drv_h;
    logic [2:0] drv_l;

    // Commutation decode, bit 0 = phase A; result is {high, low}
    function automatic logic [5:0] bcb_decode(input logic dir, input logic [2:0] code);
        logic [5:0] r;
        r = 6'h00;
        case ({dir, code})
            // Forward
            4'h9: r = {3'h1, 3'h2};
            4'hB: r = {3'h1, 3'h4};
            4'hA: r = {3'h2, 3'h4};
            4'hE: r = {3'h2, 3'h1};
            4'hC: r = {3'h4, 3'h1};
            4'hD: r = {3'h4, 3'h2};
            // Reverse
            4'h5: r = {3'h2, 3'h4};
            4'h4: r = {3'h1, 3'h4};
            4'h6: r = {3'h1, 3'h2};
            4'h2: r = {3'h4, 3'h2};
            4'h3: r = {3'h4, 3'h1};
            4'h1: r = {3'h2, 3'h1};
            // All-zero and all-one codes leave every driver off
            default: r = 6'h00;
        endcase
        return r;
    endfunction : bcb_decode

    // Synchronised views of the pins
    assign hall = s.sync2[2:0];
    assign dir_s = s.sync2[`BCB_SYNC_DIR];
    assign quad_s = s.sync2[`BCB_SYNC_QUAD];
    assign chop_s = s.sync2[`BCB_SYNC_PWM];

    // Decode of the latched position; one driver per side at most
    assign decoded = bcb_decode(dir_s, s.pos);
    assign req_hi = decoded[5:3];
    assign req_lo = decoded[2:0];

    // Next-state logic
    always_comb begin
        next_s = s;

        // Two-flop synchronisers for every pin input
        next_s.sync1 = {pwm_on, quad_select, direction,
                        position_sense_first, position_sense_second, position_sense_third};
        next_s.sync2 = s.sync1;

        // Oscillator period as a one-cycle tick
        if (s.osc_cnt == OSC_LAST) begin
            next_s.osc_cnt = 16'h0000;
            next_s.osc_tick = 1'b1;
        end else begin
            next_s.osc_cnt = s.osc_cnt + 16'h0001;
            next_s.osc_tick = 1'b0;
        end

        // Blanking window counts down on oscillator ticks
        if (s.blank_cnt != 8'h00 && s.osc_tick) begin
            next_s.blank_cnt = s.blank_cnt - 8'h01;
        end

        // Tachometer pulse counts down on system clocks
        if (s.tach_cnt != 16'h0000) begin
            next_s.tach_cnt = s.tach_cnt - 16'h0001;
        end

        // Latches are transparent until a change, then close
        if (s.blank_cnt == 8'h00 && !s.tach && hall != s.pos) begin
            next_s.pos = hall;
            next_s.blank_cnt = BLANK_TICKS;
            next_s.tach_cnt = TACH_LOAD;
        end
        next_s.tach = (next_s.tach_cnt != 16'h0000);

        // Pin stage: low side always chopped, high side only in four-quadrant mode
        next_s.quad = quad_s;
        next_s.drv_lo = drv_l & {3{chop_s}};
        next_s.drv_hi_n = ~(drv_h & {3{chop_s | ~quad_s}});
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= TOP_RST;
        end else begin
            s <= next_s;
        end
    end

    // One lockout pair per phase, six flags in all
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_phase
            bcb_lockout #(
                .DEAD_TICKS(DEAD_TICKS)
            ) u_lock (
                .mclk(mclk),
                .arst_n(arst_n),
                .osc_tick(s.osc_tick),
                .req_high(req_hi[ph]),
                .req_low(req_lo[ph]),
                .drive_high(drv_h[ph]),
                .drive_low(drv_l[ph]),
                .lock_high(),
                .lock_low()
            );
        end
    endgenerate

    // Outputs straight from flip-flops
    assign low_side_drive_a = s.drv_lo[0];
    assign low_side_drive_b = s.drv_lo[1];
    assign low_side_drive_c = s.drv_lo[2];
    assign high_side_drive_a_n = s.drv_hi_n[0];
    assign high_side_drive_b_n = s.drv_hi_n[1];
    assign high_side_drive_c_n = s.drv_hi_n[2];
    assign tach_out = s.tach;
    assign quad_mode = s.quad;

    // Checks on the commutation path
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence seq_invalid2;
        (s.pos == 3'h0 || s.pos == 3'h7) [*2];
    endsequence

    sequence seq_load;
        $changed(s.pos);
    endsequence

    a_blank_hold: assert property ((s.blank_cnt != 8'h00) |=> $stable(s.pos))
        else $error("position latch reopened during blanking");
    a_blank_load: assert property (seq_load |-> s.blank_cnt == BLANK_TICKS)
        else $error("blanking not armed on load");
    a_tach_fire: assert property (seq_load |-> s.tach && s.tach_cnt == TACH_LOAD && !$past(s.tach))
        else $error("tach pulse not fired on load");
    a_tach_block: assert property ((s.tach && $past(s.tach)) |-> $stable(s.pos))
        else $error("position changed during tach pulse");
    a_invalid_off: assert property (seq_invalid2 |=> s.drv_lo == 3'h0 && s.drv_hi_n == 3'h7)
        else $error("driver on for invalid code");
    a_one_each: assert property ($onehot0(s.drv_lo) && $onehot0(~s.drv_hi_n))
        else $error("more than one driver on a side");
    a_quad_chop: assert property ((quad_s && !chop_s) |=> s.drv_hi_n == 3'h7 && s.quad)
        else $error("high side not chopped in four-quadrant mode");
    a_decode_dir: assert property ((s.pos == 3'h1 && dir_s) |-> req_lo == 3'h2 && req_hi == 3'h1)
        else $error("forward decode of 001 wrong");

endmodule : bcb_top

// ===== hdl/bcb_params.svh
`ifndef BCB_PARAMS_SVH
`define BCB_PARAMS_SVH

// System clock period
`define BCB_CLK_NS 40
// PWM oscillator period (20 kHz)
`define BCB_OSC_PERIOD_NS 50000
// System clocks per oscillator cycle, rounded down
`define BCB_OSC_DIV (`BCB_OSC_PERIOD_NS / `BCB_CLK_NS)
// Oscillator cycles the position latches stay closed
`define BCB_BLANK_TICKS 8'h02
// Oscillator cycles a lockout flag outlives its driver
`define BCB_DEAD_TICKS 8'h02
// Tachometer pulse width
`define BCB_TACH_NS 140000
// Tachometer pulse in system clocks, rounded up
`define BCB_TACH_CYC ((`BCB_TACH_NS + `BCB_CLK_NS - 1) / `BCB_CLK_NS)
// Synchroniser input order: {pwm, quad, dir, first, second, third}
`define BCB_SYNC_W 6
`define BCB_SYNC_PWM 5
`define BCB_SYNC_QUAD 4
`define BCB_SYNC_DIR 3
// Reset levels of the drive pins
`define BCB_LOW_OFF 3'h0
`define BCB_HIGH_OFF_N 3'h7

`endif

// ===== hdl/bcb_pkg.sv
`include "bcb_params.svh"

package bcb_pkg;

    // State of one phase lockout pair
    typedef struct packed {
        logic out_h;
        logic out_l;
        logic flag_h;
        logic flag_l;
        logic [7:0] cnt_h;
        logic [7:0] cnt_l;
    } bcb_lock_t;

    // State of the commutation top
    typedef struct packed {
        logic [`BCB_SYNC_W-1:0] sync1;
        logic [`BCB_SYNC_W-1:0] sync2;
        logic [15:0] osc_cnt;
        logic osc_tick;
        logic [2:0] pos;
        logic [7:0] blank_cnt;
        logic [15:0] tach_cnt;
        logic tach;
        logic [2:0] drv_lo;
        logic [2:0] drv_hi_n;
        logic quad;
    } bcb_top_t;

endpackage : bcb_pkg

// ===== hdl/bcb_lockout.sv
`timescale 1ns/1ps
`include "bcb_params.svh"

module bcb_lockout
    import bcb_pkg::*;
#(
    parameter logic [7:0] DEAD_TICKS = `BCB_DEAD_TICKS
) (
    input wire logic mclk, // System clock
    input wire logic arst_n, // Asynchronous reset
    input wire logic osc_tick, // One pulse per oscillator cycle
    input wire logic req_high, // High-side drive wanted
    input wire logic req_low, // Low-side drive wanted
    output logic drive_high, // High-side driver on
    output logic drive_low, // Low-side driver on
    output logic lock_high, // High-side lockout flag
    output logic lock_low // Low-side lockout flag
);

    bcb_lock_t s;
    bcb_lock_t next_s;

    // Drivers open only while the opposing flag is clear
    always_comb begin
        next_s = s;
        next_s.out_h = req_high & ~req_low & ~s.flag_l;
        next_s.out_l = req_low & ~req_high & ~s.flag_h;
        // Flags set with their driver, clear after dead ticks off
        if (next_s.out_h) begin
            next_s.flag_h = 1'b1;
            next_s.cnt_h = 8'h00;
        end else if (s.flag_h && osc_tick) begin
            if (s.cnt_h == DEAD_TICKS - 8'h01) begin
                next_s.flag_h = 1'b0;
                next_s.cnt_h = 8'h00;
            end else begin
                next_s.cnt_h = s.cnt_h + 8'h01;
            end
        end
        if (next_s.out_l) begin
            next_s.flag_l = 1'b1;
            next_s.cnt_l = 8'h00;
        end else if (s.flag_l && osc_tick) begin
            if (s.cnt_l == DEAD_TICKS - 8'h01) begin
                next_s.flag_l = 1'b0;
                next_s.cnt_l = 8'h00;
            end else begin
                next_s.cnt_l = s.cnt_l + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign drive_high = s.out_h;
    assign drive_low = s.out_l;
    assign lock_high = s.flag_h;
    assign lock_low = s.flag_l;

    a_phase_excl: assert property (@(posedge mclk) disable iff (!arst_n) !(s.out_h && s.out_l))
        else $error("both drivers of a phase on");
    a_lock_follows: assert property (@(posedge mclk) disable iff (!arst_n)
        (s.out_h |-> s.flag_h) and (s.out_l |-> s.flag_l))
        else $error("lockout flag clear while driver on");
    a_dead_gap: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(s.out_h) |-> !$past(s.flag_l))
        else $error("high side on inside low-side dead time");
    a_lock_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        $fell(s.out_l) |-> s.flag_l ##1 s.flag_l)
        else $error("low-side flag cleared too soon");

endmodule : bcb_lockout

// ===== tb/bcb_hall_model.sv
`timescale 1ns/1ps

module bcb_hall_model (
    input wire logic [2:0] code, // Wanted code, first sensor in bit 2
    input wire logic allow_bad, // Permit all-high and all-low codes
    output logic first, // Sensor one
    output logic second, // Sensor two
    output logic third // Sensor three
);
    // Start from a valid position, then only 120-degree codes reach the pins unless a fault is commanded
    initial begin
        {first, second, third} = 3'h1;
        forever begin
            @(code or allow_bad);
            if (allow_bad || (code != 3'h0 && code != 3'h7)) begin
                {first, second, third} = code;
            end
        end
    end
endmodule : bcb_hall_model

// ===== tb/bcb_top_tb.sv
`timescale 1ns/1ps

module bcb_top_tb;
    import bcb_pkg::*;
    localparam int OSC = 8;
    localparam int TACH = 20;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] code = 3'h1;
    logic bad_ok = 1'b0;
    logic direction = 1'b1;
    logic quad_select = 1'b0;
    logic pwm_on = 1'b1;
    logic s1, s2, s3, tach_out, quad_mode;
    logic [2:0] lo, hi_n;
    logic [6:0] mon;
    int error_cnt = 0;
    int check_count = 0;

    // Free-running system clock
    always #20 mclk = ~mclk;
    assign mon = {tach_out, hi_n, lo};

    bcb_hall_model hall (.code(code), .allow_bad(bad_ok), .first(s1), .second(s2), .third(s3));

    bcb_top #(.OSC_DIV(OSC), .TACH_CYC(TACH)) dut (
        .mclk(mclk), .arst_n(arst_n), .position_sense_first(s1), .position_sense_second(s2),
        .position_sense_third(s3), .direction(direction), .quad_select(quad_select), .pwm_on(pwm_on),
        .low_side_drive_a(lo[0]), .low_side_drive_b(lo[1]), .low_side_drive_c(lo[2]),
        .high_side_drive_a_n(hi_n[0]), .high_side_drive_b_n(hi_n[1]), .high_side_drive_c_n(hi_n[2]),
        .tach_out(tach_out), .quad_mode(quad_mode));

    task automatic conclude;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [5:0] seen, input logic [5:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // Bounded wait for one monitored bit, returns cycles spent
    task automatic wait_bit(input int idx, input logic v, input int lim, output int n);
        n = 0;
        while (mon[idx] !== v) begin
            @(negedge mclk);
            n++;
            if (n > lim) begin
                error_cnt++;
                $display("mismatch at %0t: wait ran out", $time);
                conclude();
            end
        end
    endtask : wait_bit

    task automatic put(input logic [2:0] c, input int settle);
        @(negedge mclk);
        code = c;
        repeat (settle) @(negedge mclk);
    endtask : put

    // Drive pattern {low, high_n} from the commutation tables
    function automatic logic [5:0] expect_drv(input logic d, input logic [2:0] c);
        logic [3:0] lh;
        case (c)
            3'h1: lh = 4'h4;
            3'h3: lh = 4'h8;
            3'h2: lh = 4'h9;
            3'h6: lh = 4'h1;
            3'h4: lh = 4'h2;
            3'h5: lh = 4'h6;
            default: return 6'h07;
        endcase
        if (!d) lh = {lh[1:0], lh[3:2]};
        return {3'h1 << lh[3:2], ~(3'h1 << lh[1:0])};
    endfunction : expect_drv

    // Opposing drivers of one phase must never conduct together
    always @(negedge mclk) begin
        if (arst_n && (lo & ~hi_n) != 3'h0) check({lo, hi_n}, 6'h07, "phase overlap");
    end

    task automatic test_decode;
        logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
        for (int d = 1; d >= 0; d--) begin
            direction = d[0];
            foreach (seq[i]) begin
                put(seq[i], 100);
                check({lo, hi_n}, expect_drv(d[0], seq[i]), "decode");
            end
        end
        direction = 1'b1;
    endtask : test_decode

    task automatic test_invalid;
        bad_ok = 1'b1;
        put(3'h7, 100);
        check({lo, hi_n}, 6'h07, "all high code");
        put(3'h0, 100);
        check({lo, hi_n}, 6'h07, "all low code");
        bad_ok = 1'b0;
        put(3'h1, 100);
    endtask : test_invalid

    task automatic test_blank;
        int n, w, g;
        put(3'h3, 0);
        wait_bit(6, 1'b1, 10, n);
        check({5'h0, n >= 2 && n <= 4}, 6'h01, "input sync delay");
        put(3'h2, 0);
        wait_bit(6, 1'b0, TACH + 2, w);
        check(w[5:0], TACH[5:0] - 6'h1, "tach width");
        wait_bit(6, 1'b1, 4 * OSC, g);
        check({5'h0, w + g + 1 >= OSC}, 6'h01, "second load too early");
        check({5'h0, w + g + 1 >= TACH && w + g + 1 <= TACH + 2}, 6'h01, "load inside tach pulse");
        repeat (100) @(negedge mclk);
        check({lo, hi_n}, expect_drv(1'b1, 3'h2), "late code");
    endtask : test_blank

    task automatic test_dead;
        int n, g;
        put(3'h1, 100);
        put(3'h2, 0);
        wait_bit(1, 1'b0, 20, n);
        wait_bit(4, 1'b0, 4 * OSC, g);
        check({5'h0, g >= OSC && g <= 2 * OSC + 4}, 6'h01, "dead time");
    endtask : test_dead

    task automatic test_quad;
        put(3'h1, 100);
        pwm_on = 1'b0;
        repeat (10) @(negedge mclk);
        check({lo, hi_n}, 6'h06, "two-quadrant chop");
        quad_select = 1'b1;
        repeat (10) @(negedge mclk);
        check({lo, hi_n}, 6'h07, "four-quadrant chop");
        check({5'h0, quad_mode}, 6'h01, "quad mode");
        pwm_on = 1'b1;
        repeat (10) @(negedge mclk);
        check({lo, hi_n}, expect_drv(1'b1, 3'h1), "chop released");
    endtask : test_quad

    // Mid-run reset clears the position latch, then the pins are reloaded
    task automatic test_reset;
        @(negedge mclk);
        arst_n = 1'b0;
        @(negedge mclk);
        check({lo, hi_n}, 6'h07, "drivers in reset");
        check({4'h0, tach_out, quad_mode}, 6'h00, "tach and mode in reset");
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        repeat (100) @(negedge mclk);
        check({lo, hi_n}, expect_drv(1'b1, 3'h1), "drive after reset");
        check({5'h0, quad_mode}, 6'h01, "quad mode after reset");
    endtask : test_reset

    // Main sequence
    initial begin
        repeat (20) @(negedge mclk);
        arst_n = 1'b1;
        test_decode();
        test_invalid();
        test_blank();
        test_dead();
        test_quad();
        test_reset();
        conclude();
    end
endmodule : bcb_top_tb
